// ### src/slpm_pkg.sv
// Purpose: Shared constants and carriers for the switch link power manager
// Assumes: 100 MHz core clock, fixed port count
// Notes:   Times are kept in their own unit; cycle counts are derived
package slpm_pkg;

  localparam int          NUM_DN       = 4;
  localparam int          CLK_MHZ      = 100;
  localparam int          HOLDOFF_US   = 10;
  localparam int          HOLDOFF_CYC  = HOLDOFF_US * CLK_MHZ;
  localparam int          HCNT_W       = 10;
  localparam logic [9:0]  HOLDOFF_LOAD = 10'(HOLDOFF_CYC - 1);
  localparam logic [9:0]  HCNT_ZERO    = 10'h000;

  // Upstream L1 negotiation phases
  typedef enum logic [4:0] {
    UL_IDLE = 5'h01,
    UL_REQ  = 5'h02,
    UL_WACK = 5'h04,
    UL_DIR  = 5'h08,
    UL_TXL1 = 5'h10
  } slpm_ul_t;

  // Downstream L1 negotiation phases
  typedef enum logic [3:0] {
    DL_IDLE = 4'h1,
    DL_ACK  = 4'h2,
    DL_WEI  = 4'h4,
    DL_DIR  = 4'h8
  } slpm_dl_t;

  // Downstream turn-off / L2/L3 phases
  typedef enum logic [4:0] {
    DT_RUN   = 5'h01,
    DT_DRAIN = 5'h02,
    DT_WL23  = 5'h04,
    DT_WEI   = 5'h08,
    DT_L23   = 5'h10
  } slpm_dt_t;

  // Per-downstream-port link status inputs
  typedef struct packed {
    logic dl_active;
    logic link_down;
    logic rx_l0s_or_deeper;
    logic aspm_l1_or_deeper;
    logic aspm_l1_exit;
    logic l1_req;
    logic recovery;
    logic retrain_tx;
    logic rx_elec_idle;
    logic tlp_pending;
    logic enter_l23;
    logic pme_to_ack;
    logic enabled;
  } slpm_dn_in_t;

  // Upstream port status inputs
  typedef struct packed {
    logic l1_start;
    logic ack_rx;
    logic phy_tx_l1;
    logic phy_rx_l1;
    logic recovery_tx;
    logic recovery_rx;
    logic retrain;
    logic rx_ei_exit;
    logic turn_off_rx;
    logic tlp_pending;
    logic power_good;
    logic isolated_mode;
  } slpm_up_in_t;

endpackage

// ### src/slpm_top.sv
// Purpose: Link power management for one upstream and several downstream ports
// Assumes: All inputs synchronous to CLK_SYS; PHY and DLL handled elsewhere
// Notes:   Ports enter via packed structs; every output is a flop
`timescale 1ns/1ps
module slpm_top (
  input  wire logic                                   CLK_SYS,
  input  wire logic                                   RST,
  input  wire slpm_pkg::slpm_up_in_t                  UP_IN,
  input  wire slpm_pkg::slpm_dn_in_t [slpm_pkg::NUM_DN-1:0] DN_IN,
  output logic                                        UP_L1_REQ_SEND,
  output logic                                        UP_PHY_L1_DIR,
  output logic                                        UP_TX_L1_EXIT,
  output logic                                        UP_L0S_ALLOW,
  output logic                                        UP_L1_ALLOW,
  output logic                                        UP_L1_EXIT,
  output logic                                        UP_TO_ACK_SEND,
  output logic                                        UP_ENTER_L23_SEND,
  output logic                                        UP_L23_READY,
  output logic                                        UP_L3,
  output logic                                        UP_LINK_DOWN,
  output logic                                        BRIDGE_DL_DOWN,
  output logic [slpm_pkg::NUM_DN-1:0]                 DN_ACK_SEND,
  output logic [slpm_pkg::NUM_DN-1:0]                 DN_PHY_L1_DIR,
  output logic [slpm_pkg::NUM_DN-1:0]                 DN_L1_EXIT,
  output logic [slpm_pkg::NUM_DN-1:0]                 DN_PME_MSG_HOLD,
  output logic [slpm_pkg::NUM_DN-1:0]                 DN_TURN_OFF_SEND,
  output logic [slpm_pkg::NUM_DN-1:0]                 DN_L23_ACK_SEND,
  output logic [slpm_pkg::NUM_DN-1:0]                 DN_L23_READY,
  output logic [slpm_pkg::NUM_DN-1:0]                 DN_L3
);

  localparam int N = slpm_pkg::NUM_DN;

  typedef struct packed {
    slpm_pkg::slpm_ul_t                 ul;
    logic [slpm_pkg::HCNT_W-1:0]        uhold;
    logic                               ul_l1req, ul_dir, ul_txexit;
    logic                               l0s_ok, l1_ok, up_l1exit;
    logic                               to_pend, to_ack, l23_send, up_l23, up_l3, up_ld, br_dn;
    logic                               to_done;
    logic [N-1:0]                       acked;
    slpm_pkg::slpm_dl_t  [N-1:0]        dl;
    logic [N-1:0][slpm_pkg::HCNT_W-1:0] dhold;
    slpm_pkg::slpm_dt_t  [N-1:0]        dt;
    logic [N-1:0]                       d_ack, d_dir, d_l1x, d_hold, d_to, d_l23a, d_l23, d_l3;
  } slpm_st_t;

  slpm_st_t st_r;
  slpm_st_t st_nxt;

  // Hold-off counter step, shared by every port
  function automatic logic [slpm_pkg::HCNT_W-1:0] hold_dec(
    input logic [slpm_pkg::HCNT_W-1:0] c);
    hold_dec = (c == slpm_pkg::HCNT_ZERO) ? c : c - 10'h001;
  endfunction

  always_comb begin
    logic all_l0s, all_l1, any_l1x, all_ack, all_l23, up_recov;
    all_l0s  = 1'b1;
    all_l1   = 1'b1;
    any_l1x  = 1'b0;
    all_ack  = 1'b1;
    all_l23  = 1'b1;
    up_recov = UP_IN.recovery_tx | UP_IN.recovery_rx;
    st_nxt   = st_r;

    // Downstream scoreboard summaries
    for (int i = 0; i < N; i++) begin
      if (DN_IN[i].enabled && !DN_IN[i].link_down && !DN_IN[i].rx_l0s_or_deeper) begin
        all_l0s = 1'b0;
      end
      if (!DN_IN[i].link_down && !DN_IN[i].aspm_l1_or_deeper) begin
        all_l1 = 1'b0;
      end
      if (DN_IN[i].aspm_l1_or_deeper && DN_IN[i].aspm_l1_exit) begin
        any_l1x = 1'b1;
      end
      if (DN_IN[i].enabled && !DN_IN[i].link_down && !st_r.acked[i]) begin
        all_ack = 1'b0;
      end
      if (!DN_IN[i].link_down && st_r.dt[i] != slpm_pkg::DT_L23) begin
        all_l23 = 1'b0;
      end
    end

    // Isolated bridging port ignores the transparent ports
    if (UP_IN.isolated_mode) begin
      all_l0s = 1'b1;
      all_l1  = 1'b1;
      any_l1x = 1'b0;
      all_ack = 1'b1;
      all_l23 = 1'b1;
    end
    st_nxt.l0s_ok    = all_l0s;
    st_nxt.l1_ok     = all_l1;
    st_nxt.up_l1exit = any_l1x;

    // Upstream L1 negotiation with recovery interruption
    st_nxt.uhold     = hold_dec(st_r.uhold);
    st_nxt.ul_txexit = 1'b0;
    unique case (st_r.ul)
      slpm_pkg::UL_IDLE: begin
        if (UP_IN.l1_start && all_l1 && st_r.uhold == slpm_pkg::HCNT_ZERO) begin
          st_nxt.ul = slpm_pkg::UL_REQ;
        end
      end
      slpm_pkg::UL_REQ, slpm_pkg::UL_WACK: begin
        if (up_recov) begin
          st_nxt.ul    = slpm_pkg::UL_IDLE;
          st_nxt.uhold = slpm_pkg::HOLDOFF_LOAD;
        end else if (UP_IN.ack_rx) begin
          st_nxt.ul = slpm_pkg::UL_DIR;
        end else begin
          st_nxt.ul = slpm_pkg::UL_WACK;
        end
      end
      slpm_pkg::UL_DIR: begin
        if (up_recov) begin
          st_nxt.ul    = slpm_pkg::UL_IDLE;
          st_nxt.uhold = slpm_pkg::HOLDOFF_LOAD;
        end else if (UP_IN.phy_tx_l1) begin
          st_nxt.ul = slpm_pkg::UL_TXL1;
        end
      end
      slpm_pkg::UL_TXL1: begin
        if (!UP_IN.phy_rx_l1 && (UP_IN.recovery_rx || UP_IN.retrain)) begin
          st_nxt.ul_txexit = 1'b1;
          st_nxt.ul        = slpm_pkg::UL_IDLE;
          st_nxt.uhold     = slpm_pkg::HOLDOFF_LOAD;
        end else if (UP_IN.rx_ei_exit || any_l1x) begin
          st_nxt.ul = slpm_pkg::UL_IDLE;
        end
      end
    endcase
    st_nxt.ul_l1req = (st_nxt.ul == slpm_pkg::UL_REQ) || (st_nxt.ul == slpm_pkg::UL_WACK);
    st_nxt.ul_dir   = (st_nxt.ul == slpm_pkg::UL_DIR) || (st_nxt.ul == slpm_pkg::UL_TXL1);

    // Turn-off handshake at the upstream port
    st_nxt.to_ack = 1'b0;
    if (UP_IN.turn_off_rx) begin
      st_nxt.to_pend = 1'b1;
      st_nxt.to_done = 1'b0;
      st_nxt.acked   = '0;
    end
    for (int i = 0; i < N; i++) begin
      if (DN_IN[i].pme_to_ack) begin
        st_nxt.acked[i] = 1'b1;
      end
    end
    if (st_r.to_pend && !UP_IN.turn_off_rx && all_ack && !UP_IN.tlp_pending) begin
      st_nxt.to_ack  = 1'b1;
      st_nxt.to_pend = 1'b0;
      st_nxt.to_done = 1'b1;
      st_nxt.br_dn   = UP_IN.isolated_mode | st_r.br_dn;
    end
    // Entry waits for the upstream ack, in either mode
    st_nxt.l23_send = !st_r.up_l23 && !st_r.to_pend && st_r.to_done && all_l23;
    if (st_r.l23_send) begin
      st_nxt.up_l23 = 1'b1;
    end
    if (st_r.up_l23 && !UP_IN.power_good) begin
      st_nxt.up_l3 = 1'b1;
    end
    st_nxt.up_ld = 1'b0;
    if (st_r.up_l23 && UP_IN.rx_ei_exit) begin
      st_nxt.up_ld  = 1'b1;
      st_nxt.up_l23 = 1'b0;
      st_nxt.up_l3  = 1'b0;
      st_nxt.br_dn  = 1'b0;
      st_nxt.to_done = 1'b0;
    end

    // Downstream ports
    for (int i = 0; i < N; i++) begin
      logic drecov;
      drecov            = DN_IN[i].recovery;
      st_nxt.dhold[i]   = hold_dec(st_r.dhold[i]);
      st_nxt.d_l1x[i]   = 1'b0;
      unique case (st_r.dl[i])
        slpm_pkg::DL_IDLE: begin
          if (DN_IN[i].l1_req && st_r.dhold[i] == slpm_pkg::HCNT_ZERO) begin
            st_nxt.dl[i] = slpm_pkg::DL_ACK;
          end
        end
        slpm_pkg::DL_ACK, slpm_pkg::DL_WEI: begin
          if (drecov) begin
            st_nxt.dl[i]    = slpm_pkg::DL_IDLE;
            st_nxt.dhold[i] = slpm_pkg::HOLDOFF_LOAD;
          end else if (DN_IN[i].rx_elec_idle) begin
            st_nxt.dl[i] = slpm_pkg::DL_DIR;
          end else begin
            st_nxt.dl[i] = slpm_pkg::DL_WEI;
          end
        end
        slpm_pkg::DL_DIR: begin
          if (DN_IN[i].retrain_tx) begin
            st_nxt.dl[i]    = slpm_pkg::DL_IDLE;
            st_nxt.dhold[i] = slpm_pkg::HOLDOFF_LOAD;
          end else if (st_r.ul == slpm_pkg::UL_TXL1 && UP_IN.rx_ei_exit
                       && !UP_IN.isolated_mode) begin
            st_nxt.dl[i]    = slpm_pkg::DL_IDLE;
            st_nxt.d_l1x[i] = 1'b1;
          end
        end
      endcase
      st_nxt.d_ack[i] = st_nxt.dl[i] == slpm_pkg::DL_ACK || st_nxt.dl[i] == slpm_pkg::DL_WEI;
      st_nxt.d_dir[i] = st_nxt.dl[i] == slpm_pkg::DL_DIR;

      // Turn-off forwarding and L2/L3 entry per port
      st_nxt.d_to[i]   = 1'b0;
      st_nxt.d_l23a[i] = 1'b0;
      unique case (st_r.dt[i])
        slpm_pkg::DT_RUN: begin
          if (UP_IN.turn_off_rx && DN_IN[i].dl_active) begin
            st_nxt.dt[i] = slpm_pkg::DT_DRAIN;
          end
        end
        slpm_pkg::DT_DRAIN: begin
          if (!DN_IN[i].tlp_pending) begin
            st_nxt.d_to[i] = 1'b1;
            st_nxt.dt[i]   = slpm_pkg::DT_WL23;
          end
        end
        slpm_pkg::DT_WL23: begin
          if (DN_IN[i].enter_l23) begin
            st_nxt.d_l23a[i] = 1'b1;
            st_nxt.dt[i]     = slpm_pkg::DT_WEI;
          end
        end
        slpm_pkg::DT_WEI: begin
          if (DN_IN[i].rx_elec_idle) begin
            st_nxt.dt[i] = slpm_pkg::DT_L23;
          end
        end
        slpm_pkg::DT_L23: ; // Held until link down; power loss only flags L3
      endcase
      st_nxt.d_hold[i] = st_nxt.dt[i] != slpm_pkg::DT_RUN;
      st_nxt.d_l23[i]  = st_nxt.dt[i] == slpm_pkg::DT_L23;
      if (st_r.dt[i] == slpm_pkg::DT_L23 && !UP_IN.power_good) begin
        st_nxt.d_l3[i] = 1'b1;
      end
      if (st_r.up_ld || DN_IN[i].link_down) begin
        st_nxt.dt[i]     = slpm_pkg::DT_RUN;
        st_nxt.d_l23[i]  = 1'b0;
        st_nxt.d_hold[i] = 1'b0;
        st_nxt.d_l3[i]   = 1'b0;
      end
    end
  end

  // Single state register
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_r <= '0;
      st_r.ul <= slpm_pkg::UL_IDLE;
      for (int i = 0; i < N; i++) begin
        st_r.dl[i] <= slpm_pkg::DL_IDLE;
        st_r.dt[i] <= slpm_pkg::DT_RUN;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  assign UP_L1_REQ_SEND    = st_r.ul_l1req;
  assign UP_PHY_L1_DIR     = st_r.ul_dir;
  assign UP_TX_L1_EXIT     = st_r.ul_txexit;
  assign UP_L0S_ALLOW      = st_r.l0s_ok;
  assign UP_L1_ALLOW       = st_r.l1_ok;
  assign UP_L1_EXIT        = st_r.up_l1exit;
  assign UP_TO_ACK_SEND    = st_r.to_ack;
  assign UP_ENTER_L23_SEND = st_r.l23_send;
  assign UP_L23_READY      = st_r.up_l23;
  assign UP_L3             = st_r.up_l3;
  assign UP_LINK_DOWN      = st_r.up_ld;
  assign BRIDGE_DL_DOWN    = st_r.br_dn;
  assign DN_ACK_SEND       = st_r.d_ack;
  assign DN_PHY_L1_DIR     = st_r.d_dir;
  assign DN_L1_EXIT        = st_r.d_l1x;
  assign DN_PME_MSG_HOLD   = st_r.d_hold;
  assign DN_TURN_OFF_SEND  = st_r.d_to;
  assign DN_L23_ACK_SEND   = st_r.d_l23a;
  assign DN_L23_READY      = st_r.d_l23;
  assign DN_L3             = st_r.d_l3;

  // Checks
  chk_up_recov_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st_r.ul_l1req && UP_IN.recovery_tx) |=> !UP_L1_REQ_SEND[*2])
    else $error("upstream request kept after recovery");
  chk_up_hold_len: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st_r.ul == slpm_pkg::UL_DIR && UP_IN.recovery_rx) |=> st_r.uhold == slpm_pkg::HOLDOFF_LOAD)
    else $error("hold-off not loaded");
  chk_tx_exit: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st_r.ul == slpm_pkg::UL_TXL1 && !UP_IN.phy_rx_l1 && UP_IN.retrain) |=> UP_TX_L1_EXIT)
    else $error("tx did not leave L1");
  chk_dn_recov: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st_r.d_ack[0] && DN_IN[0].recovery) |=> !DN_ACK_SEND[0] && st_r.dhold[0] != slpm_pkg::HCNT_ZERO)
    else $error("downstream ignored recovery");
  chk_to_ack_all: assert property (@(posedge CLK_SYS) disable iff (RST)
    $rose(UP_TO_ACK_SEND) |-> !$past(UP_IN.tlp_pending))
    else $error("ack sent with pending TLPs");
  chk_l23_order: assert property (@(posedge CLK_SYS) disable iff (RST)
    DN_TURN_OFF_SEND[0] |-> $past(!DN_IN[0].tlp_pending))
    else $error("turn-off before drain");
  chk_l3_entry: assert property (@(posedge CLK_SYS) disable iff (RST)
    (UP_L23_READY && !UP_IN.power_good && !UP_IN.rx_ei_exit) |=> UP_L3)
    else $error("L3 not entered");
  chk_l1_allow: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!UP_IN.isolated_mode && !DN_IN[0].link_down && !DN_IN[0].aspm_l1_or_deeper)
    |=> !UP_L1_ALLOW)
    else $error("L1 allowed with active port");
  cov_up_l1: cover property (@(posedge CLK_SYS) st_r.ul == slpm_pkg::UL_TXL1);
  cov_to_ack: cover property (@(posedge CLK_SYS) UP_TO_ACK_SEND);
  cov_l23: cover property (@(posedge CLK_SYS) UP_ENTER_L23_SEND);

endmodule

// ### verif/slpm_far_model.sv
// Purpose: Behavioural model of the devices behind each downstream port
// Assumes: Turn-off and L23 acknowledge arrive as one-cycle pulses
// Notes:   Slow mode staggers the answers per port to shake out ordering
`timescale 1ns/1ps
module slpm_far_model (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        slow,
  input  wire logic [slpm_pkg::NUM_DN-1:0] turn_off,
  input  wire logic [slpm_pkg::NUM_DN-1:0] l23_ack,
  output logic      [slpm_pkg::NUM_DN-1:0] pme_ack,
  output logic      [slpm_pkg::NUM_DN-1:0] enter_l23,
  output logic      [slpm_pkg::NUM_DN-1:0] rx_idle
);
  int phase [slpm_pkg::NUM_DN];
  int cnt   [slpm_pkg::NUM_DN];

  // Known levels before the first falling edge
  initial begin
    pme_ack   = '0;
    enter_l23 = '0;
    rx_idle   = '0;
  end

  // Answers land on the falling edge, well away from the sampling edge
  always @(negedge clk_sys) begin
    for (int i = 0; i < slpm_pkg::NUM_DN; i++) begin
      pme_ack[i]   <= 1'b0;
      enter_l23[i] <= 1'b0;
      if (rst) begin
        phase[i]   <= 0;
        cnt[i]     <= 0;
        rx_idle[i] <= 1'b0;
      end else begin
        case (phase[i])
          0: if (turn_off[i]) begin
            phase[i] <= 1;
            cnt[i]   <= slow ? 4 + 3 * i : 0;
          end
          1, 2: if (cnt[i] != 0) begin
            cnt[i] <= cnt[i] - 1;
          end else begin
            // Power-loss preparation is the wait before the L23 request
            pme_ack[i]   <= (phase[i] == 1);
            enter_l23[i] <= (phase[i] == 2);
            phase[i]     <= phase[i] + 1;
            cnt[i]       <= slow ? 7 : 1;
          end
          3: if (l23_ack[i]) begin
            rx_idle[i] <= 1'b1;
            phase[i]   <= 4;
          end
          // Never wakes by itself; only reset returns it to phase 0
          default: ;
        endcase
      end
    end
  end
endmodule

// ### verif/slpm_top_test.sv
// Purpose: Self-checking bench for the switch link power manager
// Assumes: Hold-off is 1000 cycles; four downstream ports
// Notes:   Port 3 is kept link-down in the turn-off flows
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
`define WAITC(c, n) begin for (int k = 0; !(c); k++) begin if (k == (n)) begin \
  n_mismatch++; $display("FAIL t=%0t timeout got=%0h exp=%0h", $time, 0, 1); \
  end_sim(); end tick(1); end end
module slpm_top_test;
  localparam int N = slpm_pkg::NUM_DN;
  logic                          CLK_SYS, RST, slow, up_ack_seen, l23_seen, ld_seen, early;
  slpm_pkg::slpm_up_in_t         up_in;
  slpm_pkg::slpm_dn_in_t [N-1:0] dn_drv, dn_in;
  logic UP_L1_REQ_SEND, UP_PHY_L1_DIR, UP_TX_L1_EXIT, UP_L0S_ALLOW, UP_L1_ALLOW, UP_L1_EXIT;
  logic UP_TO_ACK_SEND, UP_ENTER_L23_SEND, UP_L23_READY, UP_L3, UP_LINK_DOWN, BRIDGE_DL_DOWN;
  logic [N-1:0] DN_ACK_SEND, DN_PHY_L1_DIR, DN_L1_EXIT, DN_PME_MSG_HOLD, DN_TURN_OFF_SEND;
  logic [N-1:0] DN_L23_ACK_SEND, DN_L23_READY, DN_L3, m_ack, m_enter, m_idle, to_seen, pme_seen;
  logic [31:0]  r;
  int           n_mismatch, tests_run, miss;

  slpm_top u_slpm_top (.CLK_SYS, .RST, .UP_IN(up_in), .DN_IN(dn_in), .UP_L1_REQ_SEND,
    .UP_PHY_L1_DIR, .UP_TX_L1_EXIT, .UP_L0S_ALLOW, .UP_L1_ALLOW, .UP_L1_EXIT, .UP_TO_ACK_SEND,
    .UP_ENTER_L23_SEND, .UP_L23_READY, .UP_L3, .UP_LINK_DOWN, .BRIDGE_DL_DOWN, .DN_ACK_SEND,
    .DN_PHY_L1_DIR, .DN_L1_EXIT, .DN_PME_MSG_HOLD, .DN_TURN_OFF_SEND, .DN_L23_ACK_SEND,
    .DN_L23_READY, .DN_L3);

  slpm_far_model u_slpm_far_model (.clk_sys(CLK_SYS), .rst(RST), .slow(slow),
    .turn_off(DN_TURN_OFF_SEND), .l23_ack(DN_L23_ACK_SEND), .pme_ack(m_ack),
    .enter_l23(m_enter), .rx_idle(m_idle));

  // Device answers replace the bench's ack and L23 fields and are ORed into its idle field
  always_comb begin
    dn_in = dn_drv;
    for (int i = 0; i < N; i++) begin
      dn_in[i].pme_to_ack   = m_ack[i];
      dn_in[i].enter_l23    = m_enter[i];
      dn_in[i].rx_elec_idle = dn_drv[i].rx_elec_idle | m_idle[i];
    end
  end

  // Sticky records, so one-cycle pulses are never missed between polls
  always @(posedge CLK_SYS) begin
    if (RST) begin
      {to_seen, pme_seen} <= '0;
      {up_ack_seen, l23_seen, ld_seen, early} <= '0;
    end else begin
      to_seen     <= to_seen | DN_TURN_OFF_SEND;
      pme_seen    <= pme_seen | m_ack;
      up_ack_seen <= up_ack_seen | UP_TO_ACK_SEND;
      l23_seen    <= l23_seen | UP_ENTER_L23_SEND;
      ld_seen     <= ld_seen | UP_LINK_DOWN;
      if (UP_TO_ACK_SEND && (pme_seen & 4'h7) != 4'h7) early <= 1'b1;
      if (UP_ENTER_L23_SEND && (DN_L23_READY & 4'h7) != 4'h7) early <= 1'b1;
    end
  end

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask

  task automatic do_reset;
    RST = 1'b1;
    tick(4);
    RST = 1'b0;
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic exp_l0s(input slpm_pkg::slpm_dn_in_t [N-1:0] d);
    exp_l0s = 1'b1;
    for (int i = 0; i < N; i++) begin
      if (d[i].enabled && !d[i].link_down && !d[i].rx_l0s_or_deeper) exp_l0s = 1'b0;
    end
  endfunction

  function automatic logic exp_l1(input slpm_pkg::slpm_dn_in_t [N-1:0] d);
    exp_l1 = 1'b1;
    for (int i = 0; i < N; i++) begin
      if (!d[i].link_down && !d[i].aspm_l1_or_deeper) exp_l1 = 1'b0;
    end
  endfunction

  // Mode 0: recovery while requesting, 1: after ack, 2: retrain with Tx in L1
  task automatic l1_try(input int mode);
    up_in.l1_start = 1'b1;
    `WAITC(UP_L1_REQ_SEND === 1'b1, 10)
    if (mode > 0) begin
      up_in.ack_rx = 1'b1;
      `WAITC(UP_PHY_L1_DIR === 1'b1, 10)
      up_in.ack_rx = 1'b0;
    end
    if (mode == 2) begin
      up_in.phy_tx_l1 = 1'b1;
      tick(2);
      up_in.retrain = 1'b1;
      `WAITC(UP_TX_L1_EXIT === 1'b1, 5)
    end else begin
      up_in.recovery_tx = (mode == 0);
      up_in.recovery_rx = (mode == 1);
      tick(1);
      {up_in.recovery_tx, up_in.recovery_rx} = 2'b00;
      tick(1);
      `CHK({UP_L1_REQ_SEND, UP_PHY_L1_DIR}, 2'b00)
      miss = 0;
      // Start is held the whole time, so any early request shows up
      repeat (900) begin
        tick(1);
        if (UP_L1_REQ_SEND !== 1'b0) miss++;
      end
      `CHK(miss, 0)
      `WAITC(UP_L1_REQ_SEND === 1'b1, 200)
    end
    up_in = '0;
    up_in.power_good = 1'b1;
    do_reset();
  endtask

  // Full turn-off handshake; ends with power loss or an upstream wake
  task automatic flow(input logic pwr);
    slow = pwr;
    up_in.isolated_mode = 1'b0;
    for (int i = 0; i < N; i++) begin
      dn_drv[i].dl_active = (i != 3);
      dn_drv[i].link_down = (i == 3);
      dn_drv[i].enabled   = (i != 3);
    end
    dn_drv[0].tlp_pending = 1'b1;
    up_in.turn_off_rx = 1'b1;
    tick(1);
    up_in.turn_off_rx = 1'b0;
    tick(4);
    `CHK(DN_PME_MSG_HOLD[0], 1'b1)
    `CHK(to_seen[0], 1'b0)
    dn_drv[0].tlp_pending = 1'b0;
    `WAITC(to_seen === 4'h7, 50)
    `WAITC(up_ack_seen === 1'b1, 300)
    tick(2);
    `CHK(BRIDGE_DL_DOWN, 1'b0)
    `WAITC(l23_seen === 1'b1, 300)
    `CHK(early, 1'b0)
    if (pwr) begin
      up_in.power_good = 1'b0;
      tick(3);
      `CHK(UP_L3, 1'b1)
      `CHK(DN_L3 & 4'h7, 4'h7)
    end else begin
      up_in.rx_ei_exit = 1'b1;
      tick(1);
      up_in.rx_ei_exit = 1'b0;
      `WAITC(ld_seen === 1'b1, 5)
      tick(3);
      `CHK(DN_L23_READY, 4'h0)
    end
    up_in = '0;
    up_in.power_good = 1'b1;
    dn_drv = '0;
    do_reset();
  endtask

  initial begin
    {RST, slow} = 2'b10;
    up_in = '0;
    up_in.power_good = 1'b1;
    dn_drv = '0;
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(32'h8713));
    @(negedge CLK_SYS);
    do_reset();
    `CHK({UP_L1_REQ_SEND, UP_TO_ACK_SEND, UP_L3, DN_L3, DN_TURN_OFF_SEND}, 11'h000)
    // Tracking of downstream states into upstream permissions
    for (int it = 0; it < 300; it++) begin
      for (int i = 0; i < N; i++) begin
        r = $urandom;
        dn_drv[i].enabled           = r[0];
        dn_drv[i].link_down         = r[1];
        dn_drv[i].rx_l0s_or_deeper  = r[2];
        dn_drv[i].aspm_l1_or_deeper = r[3];
        dn_drv[i].dl_active         = ~r[1];
      end
      tick(2);
      `CHK(UP_L0S_ALLOW, exp_l0s(dn_drv))
      `CHK(UP_L1_ALLOW, exp_l1(dn_drv))
    end
    for (int i = 0; i < N; i++) begin
      dn_drv[i].link_down         = 1'b0;
      dn_drv[i].aspm_l1_or_deeper = 1'b1;
    end
    dn_drv[2].aspm_l1_exit = 1'b1;
    tick(1);
    dn_drv[2].aspm_l1_exit = 1'b0;
    `WAITC(UP_L1_EXIT === 1'b1, 3)
    for (int m = 0; m < 3; m++) l1_try(m);
    // Downstream negotiation: recovery, retrain, then an upstream wake
    dn_drv[0].l1_req = 1'b1;
    tick(2);
    `CHK(DN_ACK_SEND[0], 1'b1)
    dn_drv[0].recovery = 1'b1;
    tick(1);
    dn_drv[0].recovery = 1'b0;
    tick(1);
    `CHK(DN_ACK_SEND[0], 1'b0)
    tick(900);
    `CHK(DN_ACK_SEND[0], 1'b0)
    `WAITC(DN_ACK_SEND[0] === 1'b1, 200)
    dn_drv[0].rx_elec_idle = 1'b1;
    tick(2);
    `CHK(DN_PHY_L1_DIR[0], 1'b1)
    dn_drv[0].retrain_tx = 1'b1;
    tick(1);
    dn_drv[0].retrain_tx = 1'b0;
    tick(1);
    `CHK(DN_PHY_L1_DIR[0], 1'b0)
    {dn_drv[1].l1_req, dn_drv[1].rx_elec_idle} = 2'b11;
    up_in.l1_start  = 1'b1;
    up_in.ack_rx    = 1'b1;
    up_in.phy_tx_l1 = 1'b1;
    `WAITC(UP_PHY_L1_DIR === 1'b1, 10)
    tick(2);
    up_in.rx_ei_exit = 1'b1;
    tick(1);
    up_in.rx_ei_exit = 1'b0;
    `CHK(DN_L1_EXIT, 4'h2)
    up_in = '0;
    up_in.power_good = 1'b1;
    dn_drv = '0;
    do_reset();
    flow(1'b0);
    flow(1'b1);
    // Isolated bridging port decides from its own traffic alone
    up_in.isolated_mode = 1'b1;
    {dn_drv[0].enabled, dn_drv[0].dl_active, dn_drv[0].tlp_pending} = 3'b111;
    tick(2);
    `CHK({UP_L0S_ALLOW, UP_L1_ALLOW}, 2'b11)
    up_in.turn_off_rx = 1'b1;
    tick(1);
    up_in.turn_off_rx = 1'b0;
    `WAITC(up_ack_seen === 1'b1, 5)
    tick(2);
    `CHK(BRIDGE_DL_DOWN, 1'b1)
    `WAITC(l23_seen === 1'b1, 5)
    end_sim();
  end
endmodule
